// >>> apoc_pkg.sv
// Constants, register map and types shared by the converter output control block.
package apoc_pkg;

   // --------------------------------------------------------------------
   // Widths and counts
   // --------------------------------------------------------------------
   localparam int DATA_W       = 10;   // Sample word width.
   localparam int PIPE_LATENCY = 12;   // Sample clocks from sampling to output.
   localparam int ADDR_W       = 8;    // Register byte address width.
   localparam int IRQ_W        = 3;    // Number of interrupt events.
   localparam int PIN_W        = 20;   // Pins passed through the synchroniser.

   // --------------------------------------------------------------------
   // Register byte offsets
   // --------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL       = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_LAST_WORD  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_SAMPLE_CNT = 8'h18;

   // --------------------------------------------------------------------
   // Field positions and reset values
   // --------------------------------------------------------------------
   localparam int CTRL_SOFT_SLEEP_BIT = 0;
   localparam int IRQ_OVR_BIT         = 0;
   localparam int IRQ_PD_BIT          = 1;
   localparam int IRQ_WAKE_BIT        = 2;
   localparam int ST_MODE_POS         = 0;
   localparam int ST_BIAS_POS         = 2;
   localparam int ST_FMT_BIT          = 4;
   localparam int ST_OE_N_BIT         = 5;
   localparam int ST_CKEN_N_BIT       = 6;
   localparam int LAST_OVR_BIT        = 16;
   localparam logic             CTRL_SOFT_SLEEP_RST = 1'b0;
   localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST      = 3'h0;

   // --------------------------------------------------------------------
   // Bias codes, one-hot bias outputs and bus responses
   // --------------------------------------------------------------------
   localparam logic [1:0] BIAS_OFF    = 2'h0;
   localparam logic [1:0] BIAS_50UA   = 2'h1;
   localparam logic [1:0] BIAS_500UA  = 2'h2;
   localparam logic [1:0] BIAS_1MA    = 2'h3;
   localparam logic [3:0] ONEHOT_OFF  = 4'h1;
   localparam logic [3:0] ONEHOT_50UA = 4'h2;
   localparam logic [3:0] ONEHOT_500U = 4'h4;
   localparam logic [3:0] ONEHOT_1MA  = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operating mode of the converter.
   typedef enum logic [1:0] {APOC_POWER_DOWN, APOC_SLEEP, APOC_ACTIVE} apoc_mode_t;

endpackage

// >>> apoc_top.sv
// Parallel output and pin control logic of a 10-bit sampling converter.
//
// What this block does
// - Sync clock driven when enable low, else tristate.
// - Format select 0 offset binary, 1 twos complement.
// - Power-down low holds whole device powered down.
// - Power-down forces data, overrange flag and sync clock outputs to zero.
// - Data outputs tristate while output enable high.
// - Overrange flag high for out-of-range samples only.
// - Output clock accompanies data for board capture.
// - Bias code selects off, 50uA, 500uA, 1mA.
// - Valid results one sample after overrange ends.
// - Only sample clock rising edge moves data; falling edge raises the sync clock.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module apoc_top
   import apoc_pkg::*;
#(
   parameter int LATENCY = PIPE_LATENCY
)
(
   input  wire logic              clk,                     // System clock, 20 MHz.
   input  wire logic              rst,                     // Synchronous reset, high.
   input  wire logic              sample_clock_pos,        // Sample clock, true side.
   input  wire logic              sample_clock_neg,        // Sample clock, inverted side.
   input  wire logic [DATA_W-1:0] core_code,               // Raw offset-binary code.
   input  wire logic              core_overrange,          // Core input out of range.
   input  wire logic              sync_clock_out_enable_n, // Output clock enable, low.
   input  wire logic              format_select,           // Output data format.
   input  wire logic              power_down_n,            // Full power-down, low.
   input  wire logic              output_enable_n,         // Data output enable, low.
   input  wire logic              sleep_n,                 // Sleep mode, low.
   input  wire logic [1:0]        cm_buffer_bias_sel,      // Reference buffer bias code.
   output logic [DATA_W-1:0]      data_out,                // Parallel sample word.
   output logic                   data_out_oe,             // Drive enable of data pins.
   output logic                   overrange_flag,          // Overrange of current word.
   output logic                   overrange_flag_oe,       // Drive enable of flag pin.
   output logic                   sync_clock_out,          // Data capture clock.
   output logic                   sync_clock_out_oe,       // Drive enable of clock pin.
   output logic [3:0]             cm_bias_onehot,          // Buffer bias selection.
   output logic                   irq,                     // Level interrupt.
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,            // Write address.
   input  wire logic              s_axi_awvalid,           // Write address valid.
   output logic                   s_axi_awready,           // Write address ready.
   input  wire logic [31:0]       s_axi_wdata,             // Write data.
   input  wire logic [3:0]        s_axi_wstrb,             // Write byte strobes.
   input  wire logic              s_axi_wvalid,            // Write data valid.
   output logic                   s_axi_wready,            // Write data ready.
   output logic [1:0]             s_axi_bresp,             // Write response.
   output logic                   s_axi_bvalid,            // Write response valid.
   input  wire logic              s_axi_bready,            // Write response ready.
   input  wire logic [ADDR_W-1:0] s_axi_araddr,            // Read address.
   input  wire logic              s_axi_arvalid,           // Read address valid.
   output logic                   s_axi_arready,           // Read address ready.
   output logic [31:0]            s_axi_rdata,             // Read data.
   output logic [1:0]             s_axi_rresp,             // Read response.
   output logic                   s_axi_rvalid,            // Read data valid.
   input  wire logic              s_axi_rready             // Read data ready.
);

   // ---------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------
   logic [PIN_W-1:0]  pin_meta_ff, pin_sync_ff;
   logic [DATA_W-1:0] code_s, data_out_ff;
   logic [DATA_W-1:0] code_pipe_ff [LATENCY];
   logic              over_pipe_ff [LATENCY];
   logic              clk_level_ff, clk_level_s, rise, active, shift;
   logic              over_s, cken_n_s, fmt_s, pd_n_s, oe_n_s, sleep_n_s;
   logic [1:0]        bias_s, bresp_ff, rresp_ff;
   apoc_mode_t        mode_ff, nxt_mode;
   logic              overrange_flag_ff, data_out_oe_ff, sync_clock_out_ff, sync_clock_out_oe_ff;
   logic [3:0]        cm_bias_onehot_ff, w_strb_ff;
   logic [31:0]       sample_cnt_ff, w_data_ff, rdata_ff, rd_word;
   logic              soft_sleep_ff, irq_ff;
   logic [IRQ_W-1:0]  irq_status_ff, irq_enable_ff, irq_event, irq_clear;
   logic              awready_ff, wready_ff, aw_full_ff, w_full_ff, bvalid_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic              arready_ff, rvalid_ff, aw_take, w_take, do_write;
   logic              nxt_aw_full, nxt_w_full, ar_take, rd_hit, wr_hit;

   // ---------------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------------
   // Every pin and the core word pass two flops. The core word is stable for
   // a whole sample period, so its bits cannot tear when caught after a rise.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end
      else
      begin
         pin_meta_ff <= {sample_clock_pos, sample_clock_neg, core_overrange, core_code,
                         sync_clock_out_enable_n, format_select, power_down_n,
                         output_enable_n, sleep_n, cm_buffer_bias_sel};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Synchronised fields; a grounded inverted side gives a plain CMOS clock.
   assign {over_s, code_s, cken_n_s, fmt_s, pd_n_s, oe_n_s, sleep_n_s, bias_s} = pin_sync_ff[17:0];
   assign clk_level_s = pin_sync_ff[19] & ~pin_sync_ff[18];

   // ---------------------------------------------------------------------
   // Sample clock edge detection
   // ---------------------------------------------------------------------
   // Only the rising edge is looked for; a falling edge only raises the capture clock.
   always_ff @(posedge clk)
   begin
      if (rst)
         clk_level_ff <= 1'b0;
      else
         clk_level_ff <= clk_level_s;
   end

   assign rise = clk_level_s & ~clk_level_ff;

   // ---------------------------------------------------------------------
   // Operating mode
   // ---------------------------------------------------------------------
   // Power-down has priority over sleep; software sleep joins the pin.
   always_comb
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         APOC_POWER_DOWN, APOC_SLEEP, APOC_ACTIVE:
         begin
            if (!pd_n_s)
               nxt_mode = APOC_POWER_DOWN;
            else if (!sleep_n_s || soft_sleep_ff)
               nxt_mode = APOC_SLEEP;
            else
               nxt_mode = APOC_ACTIVE;
         end
         default:
            nxt_mode = APOC_POWER_DOWN;
      endcase
   end

   // Reset leaves the device powered down until the pin is seen high.
   always_ff @(posedge clk)
   begin
      if (rst)
         mode_ff <= APOC_POWER_DOWN;
      else
         mode_ff <= nxt_mode;
   end

   assign active = (mode_ff == APOC_ACTIVE);
   assign shift  = active & rise;

   // ---------------------------------------------------------------------
   // Conversion pipeline
   // ---------------------------------------------------------------------
   // Stage 0 clamps an overrange sample to the rail given by its MSB, and a
   // sample back in range passes unchanged at the very next edge.
   always_ff @(posedge clk)
   begin
      if (rst || mode_ff == APOC_POWER_DOWN)
      begin
         code_pipe_ff[0] <= '0;
         over_pipe_ff[0] <= 1'b0;
      end
      else if (shift)
      begin
         code_pipe_ff[0] <= over_s ? {DATA_W{code_s[DATA_W-1]}} : code_s;
         over_pipe_ff[0] <= over_s;
      end
   end

   // Later stages only delay; power-down clears them so no stale word leaks.
   for (genvar g = 1; g < LATENCY; g++)
   begin : g_pipe
      always_ff @(posedge clk)
      begin
         if (rst || mode_ff == APOC_POWER_DOWN)
         begin
            code_pipe_ff[g] <= '0;
            over_pipe_ff[g] <= 1'b0;
         end
         else if (shift)
         begin
            code_pipe_ff[g] <= code_pipe_ff[g-1];
            over_pipe_ff[g] <= over_pipe_ff[g-1];
         end
      end
   end

   // ---------------------------------------------------------------------
   // Output word, flag and capture clock
   // ---------------------------------------------------------------------
   // Format is applied at the output so a change takes effect next word.
   always_ff @(posedge clk)
   begin
      if (rst || mode_ff == APOC_POWER_DOWN)
      begin
         data_out_ff       <= '0;
         overrange_flag_ff <= 1'b0;
      end
      else if (shift)
      begin
         data_out_ff <= {code_pipe_ff[LATENCY-1][DATA_W-1] ^ fmt_s,
                         code_pipe_ff[LATENCY-1][DATA_W-2:0]};
         overrange_flag_ff <= over_pipe_ff[LATENCY-1];
      end
   end

   // The capture clock falls as the word changes and rises mid-period, so
   // the board registers on its rising edge with half a period of margin.
   always_ff @(posedge clk)
   begin
      if (rst || !active)
         sync_clock_out_ff <= 1'b0;
      else
         sync_clock_out_ff <= ~clk_level_s;
   end

   // Drive enables follow the pins in every mode.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         data_out_oe_ff       <= 1'b0;
         sync_clock_out_oe_ff <= 1'b0;
      end
      else
      begin
         data_out_oe_ff       <= ~oe_n_s;
         sync_clock_out_oe_ff <= ~cken_n_s;
      end
   end

   // ---------------------------------------------------------------------
   // Reference buffer bias decode
   // ---------------------------------------------------------------------
   // A powered-down device keeps the buffer off whatever the pins say.
   always_ff @(posedge clk)
   begin
      if (rst || mode_ff == APOC_POWER_DOWN)
         cm_bias_onehot_ff <= ONEHOT_OFF;
      else
      begin
         case (bias_s)
            BIAS_OFF:   cm_bias_onehot_ff <= ONEHOT_OFF;
            BIAS_50UA:  cm_bias_onehot_ff <= ONEHOT_50UA;
            BIAS_500UA: cm_bias_onehot_ff <= ONEHOT_500U;
            BIAS_1MA:   cm_bias_onehot_ff <= ONEHOT_1MA;
            default:    cm_bias_onehot_ff <= ONEHOT_OFF;
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Sample counter and interrupts
   // ---------------------------------------------------------------------
   // Counts words put out since reset; wraps silently.
   always_ff @(posedge clk)
   begin
      if (rst)
         sample_cnt_ff <= '0;
      else if (shift)
         sample_cnt_ff <= sample_cnt_ff + 32'h1;
   end

   assign irq_event[IRQ_OVR_BIT]  = shift & over_pipe_ff[LATENCY-1];
   assign irq_event[IRQ_PD_BIT]   = (nxt_mode == APOC_POWER_DOWN) & (mode_ff != APOC_POWER_DOWN);
   assign irq_event[IRQ_WAKE_BIT] = (nxt_mode == APOC_ACTIVE) & ~active;
   assign irq_clear = (do_write && aw_addr_ff == OFF_IRQ_CLEAR && w_strb_ff[0]) ?
                      w_data_ff[IRQ_W-1:0] : '0;

   // A new event outranks a clear arriving in the same cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_status_ff <= '0;
         irq_ff        <= 1'b0;
      end
      else
      begin
         irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_event;
         irq_ff        <= |(irq_status_ff & irq_enable_ff);
      end
   end

   // ---------------------------------------------------------------------
   // Register bus write path
   // ---------------------------------------------------------------------
   assign aw_take     = s_axi_awvalid & awready_ff;
   assign w_take      = s_axi_wvalid & wready_ff;
   assign do_write    = aw_full_ff & w_full_ff & ~bvalid_ff;
   assign nxt_aw_full = (aw_full_ff | aw_take) & ~do_write;
   assign nxt_w_full  = (w_full_ff | w_take) & ~do_write;
   assign wr_hit      = (aw_addr_ff == OFF_CTRL) || (aw_addr_ff == OFF_IRQ_CLEAR) ||
                        (aw_addr_ff == OFF_IRQ_ENABLE);

   // Address and data are held independently; one write is done at a time.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_full_ff <= 1'b0;
         w_full_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff  <= '0;
         w_strb_ff  <= '0;
      end
      else
      begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff  <= nxt_w_full;
         awready_ff <= ~nxt_aw_full;
         wready_ff  <= ~nxt_w_full;
         if (aw_take)
            aw_addr_ff <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
      end
   end

   // Writable registers; status registers ignore writes and answer them with a slave error.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         soft_sleep_ff <= CTRL_SOFT_SLEEP_RST;
         irq_enable_ff <= IRQ_ENABLE_RST;
      end
      else if (do_write && w_strb_ff[0])
      begin
         if (aw_addr_ff == OFF_CTRL)
            soft_sleep_ff <= w_data_ff[CTRL_SOFT_SLEEP_BIT];
         if (aw_addr_ff == OFF_IRQ_ENABLE)
            irq_enable_ff <= w_data_ff[IRQ_W-1:0];
      end
   end

   // Unmapped writes are answered with a slave error.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_ff <= 1'b0;
   end

   // ---------------------------------------------------------------------
   // Register bus read path
   // ---------------------------------------------------------------------
   always_comb
   begin
      rd_word = '0;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         OFF_CTRL:       rd_word[CTRL_SOFT_SLEEP_BIT] = soft_sleep_ff;
         OFF_STATUS:
         begin
            rd_word[ST_MODE_POS+:2] = mode_ff;
            rd_word[ST_BIAS_POS+:2] = bias_s;
            rd_word[ST_FMT_BIT]     = fmt_s;
            rd_word[ST_OE_N_BIT]    = oe_n_s;
            rd_word[ST_CKEN_N_BIT]  = cken_n_s;
         end
         OFF_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status_ff;
         OFF_IRQ_CLEAR:  rd_word = '0;
         OFF_IRQ_ENABLE: rd_word[IRQ_W-1:0] = irq_enable_ff;
         OFF_LAST_WORD:
         begin
            rd_word[DATA_W-1:0]  = data_out_ff;
            rd_word[LAST_OVR_BIT] = overrange_flag_ff;
         end
         OFF_SAMPLE_CNT: rd_word = sample_cnt_ff;
         default:        rd_hit = 1'b0;
      endcase
   end

   assign ar_take = s_axi_arvalid & arready_ff;

   // The answer is registered one cycle after the address is taken.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rd_word;
         rresp_ff   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
      else if (!rvalid_ff)
         arready_ff <= 1'b1;
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   assign {data_out, data_out_oe, overrange_flag, overrange_flag_oe} =
          {data_out_ff, data_out_oe_ff, overrange_flag_ff, data_out_oe_ff};
   assign {sync_clock_out, sync_clock_out_oe, cm_bias_onehot, irq} =
          {sync_clock_out_ff, sync_clock_out_oe_ff, cm_bias_onehot_ff, irq_ff};
   assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} =
          {awready_ff, wready_ff, bvalid_ff, bresp_ff};
   assign {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} =
          {arready_ff, rvalid_ff, rdata_ff, rresp_ff};

endmodule

// >>> apoc_sva.sv
// Assertions on the pin side of the converter output control block.
`timescale 1ns/1ps
module apoc_sva
   import apoc_pkg::*;
(
   input wire logic              clk,                     // Clock.
   input wire logic              rst,                     // Reset.
   input wire logic              sample_clock_pos,        // Sample clock.
   input wire logic              sync_clock_out_enable_n, // Clock pin enable.
   input wire logic              power_down_n,            // Power-down.
   input wire logic              output_enable_n,         // Data pin enable.
   input wire logic              sleep_n,                 // Sleep.
   input wire logic [1:0]        cm_buffer_bias_sel,      // Bias code.
   input wire logic [DATA_W-1:0] data_out,                // Word.
   input wire logic              data_out_oe,             // Data drive.
   input wire logic              overrange_flag,          // Flag.
   input wire logic              sync_clock_out,          // Capture clock.
   input wire logic              sync_clock_out_oe,       // Clock drive.
   input wire logic [3:0]        cm_bias_onehot           // Bias select.
);
   // Pins pass a two-flop synchroniser, so five steady samples leave margin.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_pd_held;
      !power_down_n[*5];
   endsequence
   a_clock_pin_drive: assert property ($stable(sync_clock_out_enable_n)[*5] |->
      sync_clock_out_oe == !sync_clock_out_enable_n) else $error("clock pin drive wrong");
   a_data_pin_drive: assert property ($stable(output_enable_n)[*5] |->
      data_out_oe == !output_enable_n) else $error("data pin drive wrong");
   a_pd_zero_out: assert property (s_pd_held |-> data_out == 10'h000 &&
      !overrange_flag && !sync_clock_out) else $error("outputs not zero in power-down");
   a_pd_bias_off: assert property (s_pd_held |-> cm_bias_onehot == ONEHOT_OFF)
      else $error("bias on in power-down");
   a_bias_decode: assert property (($stable(cm_buffer_bias_sel) && power_down_n)[*5] |->
      cm_bias_onehot == (4'h1 << cm_buffer_bias_sel)) else $error("bias decode wrong");
   a_ovr_clamped: assert property (overrange_flag |-> data_out[8:0] == {9{data_out[8]}})
      else $error("flagged word not clamped");
   // A word may only change a few cycles after a rising sample clock edge.
   a_rise_only: assert property ($changed(data_out) && power_down_n |->
      $past(sample_clock_pos, 2) && !$past(sample_clock_pos, 6)) else $error("word moved off rise");
   a_sleep_hold: assert property ((power_down_n && !sleep_n)[*5] |=>
      $stable(data_out) && !sync_clock_out) else $error("word moved in sleep");
endmodule
bind apoc_top apoc_sva apoc_sva_inst (.*);

// >>> apoc_capture.sv
// Board-side capture register that takes the word on the sync clock pin.
`timescale 1ns/1ps
module apoc_capture
   import apoc_pkg::*;
(
   input  wire logic              cap_clk,  // Sync clock pin.
   input  wire logic [DATA_W-1:0] data_pin, // Data pins.
   input  wire logic              flag_pin, // Overrange pin.
   output logic      [DATA_W-1:0] word_ff,  // Captured word.
   output logic                   flag_ff   // Captured flag.
);
   // Rising edge falls mid-way through the word, away from its changes.
   always_ff @(posedge cap_clk)
   begin
      word_ff <= data_pin;
      flag_ff <= flag_pin;
   end
endmodule

// >>> apoc_top_tb.sv
// Self-checking bench for the converter output control block.
`timescale 1ns/1ps
module apoc_top_tb
   import apoc_pkg::*;
;
   logic              clk = 1'b0, rst = 1'b1, sample_clock_pos = 1'b0, core_overrange = 1'b0;
   logic              sync_clock_out_enable_n = 1'b0, format_select = 1'b0, sleep_n = 1'b1;
   logic              power_down_n = 1'b0, output_enable_n = 1'b0, flag_ff;
   logic              data_out_oe, overrange_flag, overrange_flag_oe, sync_clock_out, irq;
   logic              sync_clock_out_oe, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic              s_axi_arready, s_axi_rvalid;
   logic [1:0]        cm_buffer_bias_sel = 2'h1, s_axi_bresp, s_axi_rresp;
   logic [3:0]        cm_bias_onehot;
   logic [DATA_W-1:0] core_code = 10'h000, data_out, word_ff;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
   int                n_errors = 0, tests_run = 0, cyc = 0;
   localparam logic [11:0] TBL [6] = '{12'h004, 12'hB15, 12'hFC2, 12'h403, 12'h554, 12'hAA9};
   // Released pins read back inverted; the clock pin has a pull-down.
   wire logic [DATA_W-1:0] data_pin = data_out_oe ? data_out : ~word_ff;
   wire logic              flag_pin = overrange_flag_oe ? overrange_flag : ~flag_ff;
   apoc_top #(.LATENCY(2)) apoc_top_inst (.*, .sample_clock_neg(1'b0), .s_axi_wstrb(4'hF),
      .s_axi_bready(1'b1), .s_axi_rready(1'b1));
   apoc_capture apoc_capture_inst (.cap_clk(sync_clock_out_oe & sync_clock_out),
      .data_pin(data_pin), .flag_pin(flag_pin), .word_ff(word_ff), .flag_ff(flag_ff));
   // System and sample clocks.
   always #25 clk = ~clk;
   initial #37 forever #200 sample_clock_pos = ~sample_clock_pos;
   // Cycle ceiling with wide margin.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_errors = n_errors + 1;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Each channel is held until its ready is seen.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      chk("bresp", er, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      if (er === RESP_OKAY) chk("rdata", exp, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   // Inputs change after a falling sample edge.
   task automatic step(input logic [9:0] c, input logic o, input logic f);
      @(negedge sample_clock_pos);
      @(posedge clk);
      core_code      <= c;
      core_overrange <= o;
      format_select  <= f;
      repeat (5) @(posedge sample_clock_pos);
      repeat (2) @(posedge clk);
   endtask
   // Overrange clamps to the code's MSB side; format flips the MSB.
   function automatic logic [9:0] xword(input logic [9:0] c, input logic o, input logic f);
      logic [9:0] v;
      v = o ? {10{c[9]}} : c;
      return {v[9] ^ f, v[8:0]};
   endfunction
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFF_CTRL, 32'h0, RESP_OKAY);
      rd(OFF_IRQ_ENABLE, 32'h0, RESP_OKAY);
      rd(8'h1C, 32'h0, RESP_SLVERR);
      wr(OFF_STATUS, 32'hFF, RESP_SLVERR);
      wr(OFF_CTRL, 32'h1, RESP_OKAY);
      rd(OFF_CTRL, 32'h1, RESP_OKAY);
      wr(OFF_CTRL, 32'h0, RESP_OKAY);
      $display("registers done");
      power_down_n <= 1'b1;
      foreach (TBL[i])
      begin
         step(TBL[i][11:2], TBL[i][1], TBL[i][0]);
         chk("word", xword(TBL[i][11:2], TBL[i][1], TBL[i][0]), word_ff);
         chk("flag", TBL[i][1], flag_ff);
      end
      chk("data oe", 1, data_out_oe);
      chk("clock oe", 1, sync_clock_out_oe);
      rd(OFF_LAST_WORD, 32'h0AA, RESP_OKAY);
      $display("sample path done");
      rd(OFF_IRQ_STATUS, 32'h5, RESP_OKAY);
      chk("irq masked", 0, irq);
      wr(OFF_IRQ_ENABLE, 32'h1, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("irq on", 1, irq);
      wr(OFF_IRQ_CLEAR, 32'h1, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("irq off", 0, irq);
      rd(OFF_IRQ_STATUS, 32'h4, RESP_OKAY);
      $display("interrupt done");
      sleep_n <= 1'b0;
      step(10'h3C3, 1'b0, 1'b0);
      chk("sleep word", 32'h0AA, data_out);
      sleep_n <= 1'b1;
      step(10'h3C3, 1'b0, 1'b0);
      chk("wake word", 32'h3C3, word_ff);
      power_down_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk("pd word", 0, data_out);
      chk("pd bias", ONEHOT_OFF, cm_bias_onehot);
      rd(OFF_IRQ_STATUS, 32'h6, RESP_OKAY);
      power_down_n <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         cm_buffer_bias_sel <= 2'(i);
         repeat (5) @(posedge clk);
         chk("bias", 32'h1 << i, cm_bias_onehot);
      end
      output_enable_n         <= 1'b1;
      sync_clock_out_enable_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk("data oe", 0, data_out_oe);
      chk("clock oe", 0, sync_clock_out_oe);
      chk("flag oe", 0, overrange_flag_oe);
      rd(OFF_STATUS, 32'h6E, RESP_OKAY);
      $display("modes done");
      conclude();
   end
endmodule
